//--- design/pqs_event_status.sv
// sticky interrupt status with mask and one level interrupt output.
// assumes the clear comes with a snapshot of the bits the reader saw.
`timescale 1ns/1ps
module pqs_event_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // events and read-to-clear
  input wire logic [pqs_pkg::EV_W-1:0] ev_set,
  input wire logic rd_clr,
  input wire logic [pqs_pkg::EV_W-1:0] snap,
  input wire logic [pqs_pkg::EV_W-1:0] mask,
  // status out
  output logic [pqs_pkg::EV_W-1:0] status,
  output logic irq
);

  typedef struct packed {
    logic [pqs_pkg::EV_W-1:0] status;
  } pqs_evst_s;

  pqs_evst_s st;
  pqs_evst_s next_st;

  // ----------------------------------------------------------------
  // sticky bits
  // ----------------------------------------------------------------
  // only bits the reader actually saw are cleared; new events win
  always_comb begin
    next_st = st;
    next_st.status = ev_set | (st.status & ~(rd_clr ? snap : '0));
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign irq = |(st.status & mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_irq_level;
    @(posedge core_clk) disable iff (srst)
      (|(ev_set & mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("masked event did not raise irq");

  property p_sticky_hold;
    @(posedge core_clk) disable iff (srst)
      (!rd_clr && (|st.status)) |=> ((st.status & $past(st.status)) == $past(st.status));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("status bit lost without a read");

endmodule : pqs_event_status

//--- design/pqs_pin_sync.sv
// three-stage synchroniser for status levels arriving from other logic.
// assumes the levels are slow; a change counts once stages two and three agree.
`timescale 1ns/1ps
module pqs_pin_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] lvl_in,
  output logic [W-1:0] lvl_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pqs_sync_s;

  pqs_sync_s st;
  pqs_sync_s next_st;

  // ----------------------------------------------------------------
  // shift and agree
  // ----------------------------------------------------------------
  // s1 feeds only s2, so no logic ever sees a metastable value
  always_comb begin
    next_st = st;
    next_st.s1 = lvl_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lvl_out = st.q;

endmodule : pqs_pin_sync

//--- design/pqs_pkg.sv
// package for the phy quick status block: register indices, field positions,
// reset values and widths shared by the bank and its irq unit; the synchroniser takes its width as a parameter.
// assumes a 32-bit apb slave with one register per aligned word.
package pqs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int CNT_W = 8;
  localparam int EV_W = 8;
  localparam int LVL_W = 5;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_BASIC_STATUS = 6'h01;
  localparam logic [IDX_W-1:0] IDX_NEG_EXPANSION = 6'h06;
  localparam logic [IDX_W-1:0] IDX_QUICK_STATUS = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h13;
  localparam logic [IDX_W-1:0] IDX_FC_COUNTER = 6'h14;
  localparam logic [IDX_W-1:0] IDX_RXERR_COUNTER = 6'h15;
  localparam logic [IDX_W-1:0] IDX_PHY_CONTROL = 6'h19;
  localparam logic [IDX_W-1:0] IDX_TEN_STATUS = 6'h1A;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  // ----------------------------------------------------------------
  // quick status field positions
  // ----------------------------------------------------------------
  localparam int QS_RSVD = 15;
  localparam int QS_XOVER = 14;
  localparam int QS_RXERR = 13;
  localparam int QS_POL = 12;
  localparam int QS_FC = 11;
  localparam int QS_SIGDET = 10;
  localparam int QS_LOCK = 9;
  localparam int QS_PAGE = 8;
  localparam int QS_IRQ = 7;
  localparam int QS_RFAULT = 6;

  // ----------------------------------------------------------------
  // other register fields
  // ----------------------------------------------------------------
  localparam int BS_RFAULT = 4;
  localparam int NE_PAGE = 1;
  localparam int TS_POL = 4;
  localparam int CTL_FORCE = 0;
  localparam int CTL_AUTO = 1;

  // ----------------------------------------------------------------
  // event bits of the interrupt status register
  // ----------------------------------------------------------------
  localparam int EV_RXERR = 0;
  localparam int EV_FC = 1;
  localparam int EV_POL = 2;
  localparam int EV_SIGLOSS = 3;
  localparam int EV_LOCKLOSS = 4;
  localparam int EV_PAGE = 5;
  localparam int EV_RFAULT = 6;
  localparam int EV_XOVER = 7;

  // ----------------------------------------------------------------
  // synchronised level positions
  // ----------------------------------------------------------------
  localparam int LV_SIGDET = 0;
  localparam int LV_LOCK = 1;
  localparam int LV_POL = 2;
  localparam int LV_RFAULT = 3;
  localparam int LV_SWAP = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic CTL_AUTO_RST = 1'b1;
  localparam logic CTL_FORCE_RST = 1'b0;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

endpackage : pqs_pkg

//--- design/pqs_quick_status.sv
// phy quick status register bank with its source registers, as an apb slave.
// assumes status events come as one-cycle pulses on core_clk and that the
// status levels come from other logic and are synchronised here.
//
// Function
// - bit 15 ignores writes, reads zero
// - crossover bit one when pairs swapped
// - crossover follows enable, force and swaps
// - receive-error latch set, cleared by counter read
// - polarity mirrors ten-status bit, cleared there
// - false-carrier latch set, cleared by counter read
// - signal detect latched low until read
// - descrambler lock latched low until read
// - page received copies expansion flag bit
// - interrupt pending while irq pending, status clears
// - remote fault set, cleared by basic status
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module pqs_quick_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pqs_pkg::ADDR_W-1:0] paddr,
  input wire logic [pqs_pkg::DATA_W-1:0] pwdata,
  output logic [pqs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // event pulses from same-clock logic
  input wire logic rx_error_evt,
  input wire logic false_carrier_evt,
  input wire logic page_received_evt,
  // status levels from other logic
  input wire logic signal_detect,
  input wire logic descrambler_lock,
  input wire logic polarity_inverted,
  input wire logic remote_fault_ind,
  input wire logic pair_swap,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [pqs_pkg::DATA_W-1:0] prdata;
    logic err;
    logic ctl_auto;
    logic ctl_force;
    logic [pqs_pkg::EV_W-1:0] mask;
    logic xover;
    logic rxerr_l;
    logic fc_l;
    logic pol_l;
    logic page_l;
    logic rf_l;
    logic sd_ll;
    logic lock_ll;
    logic [pqs_pkg::CNT_W-1:0] rxerr_cnt;
    logic [pqs_pkg::CNT_W-1:0] fc_cnt;
    logic [pqs_pkg::LVL_W-1:0] lvl_q;
  } pqs_bank_s;

  pqs_bank_s st;
  pqs_bank_s next_st;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // access of a given register in the access phase
  function automatic logic hit_of(input logic acc, input logic [pqs_pkg::IDX_W-1:0] idx,
                                  input logic [pqs_pkg::IDX_W-1:0] want);
    hit_of = acc && (idx == want);
  endfunction : hit_of

  // latched-high flag: set wins over clear
  function automatic logic latch_hi(input logic cur, input logic set, input logic clr);
    latch_hi = set | (cur & ~clr);
  endfunction : latch_hi

  // counter minus what the reader saw, plus a new event, saturating
  function automatic logic [pqs_pkg::CNT_W-1:0] cnt_step(input logic [pqs_pkg::CNT_W-1:0] cnt,
                                                         input logic [pqs_pkg::CNT_W-1:0] sub,
                                                         input logic ev);
    logic [pqs_pkg::CNT_W:0] t;
    t = {1'b0, cnt} - {1'b0, sub};
    if (ev && (t[pqs_pkg::CNT_W-1:0] != pqs_pkg::CNT_MAX)) begin
      t = t + {1'b0, pqs_pkg::CNT_ONE};
    end
    cnt_step = t[pqs_pkg::CNT_W-1:0];
  endfunction : cnt_step

  // ----------------------------------------------------------------
  // level synchroniser
  // ----------------------------------------------------------------
  logic [pqs_pkg::LVL_W-1:0] lvl_raw;
  logic [pqs_pkg::LVL_W-1:0] lvl_s;

  // levels come from logic on other clocks, hence three stages
  always_comb begin
    lvl_raw = '0;
    lvl_raw[pqs_pkg::LV_SIGDET] = signal_detect;
    lvl_raw[pqs_pkg::LV_LOCK] = descrambler_lock;
    lvl_raw[pqs_pkg::LV_POL] = polarity_inverted;
    lvl_raw[pqs_pkg::LV_RFAULT] = remote_fault_ind;
    lvl_raw[pqs_pkg::LV_SWAP] = pair_swap;
  end

  pqs_pin_sync #(
    .W(pqs_pkg::LVL_W)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .lvl_in(lvl_raw),
    .lvl_out(lvl_s)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [pqs_pkg::IDX_W-1:0] idx;
  logic setup;
  logic rd_acc;
  logic wr_acc;
  logic known;
  logic rd_qs;
  logic rd_rxc;
  logic rd_fcc;
  logic rd_neg;
  logic rd_ten;
  logic rd_bas;
  logic rd_irq;

  assign idx = paddr[pqs_pkg::IDX_LSB +: pqs_pkg::IDX_W];
  assign setup = psel && !penable;
  // misaligned accesses only get an error: no write lands and no read clears a flag
  assign rd_acc = psel && penable && !pwrite && (paddr[pqs_pkg::IDX_LSB-1:0] == pqs_pkg::ALIGN_OK);
  assign wr_acc = psel && penable && pwrite && (paddr[pqs_pkg::IDX_LSB-1:0] == pqs_pkg::ALIGN_OK);
  // zero wait states: every access completes in its first access cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && st.err;

  // read strobes that clear flags; a summary read reloads its own latched-low bits
  assign rd_qs = hit_of(rd_acc, idx, pqs_pkg::IDX_QUICK_STATUS);
  assign rd_rxc = hit_of(rd_acc, idx, pqs_pkg::IDX_RXERR_COUNTER);
  assign rd_fcc = hit_of(rd_acc, idx, pqs_pkg::IDX_FC_COUNTER);
  assign rd_neg = hit_of(rd_acc, idx, pqs_pkg::IDX_NEG_EXPANSION);
  assign rd_ten = hit_of(rd_acc, idx, pqs_pkg::IDX_TEN_STATUS);
  assign rd_bas = hit_of(rd_acc, idx, pqs_pkg::IDX_BASIC_STATUS);
  assign rd_irq = hit_of(rd_acc, idx, pqs_pkg::IDX_IRQ_STATUS);

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  logic xover_now;
  logic [pqs_pkg::EV_W-1:0] ev_set;
  logic [pqs_pkg::EV_W-1:0] irq_status;

  // force wins over the detector; with auto and force both off the pairs stay normal
  assign xover_now = st.ctl_force | (st.ctl_auto & lvl_s[pqs_pkg::LV_SWAP]);

  // edges are taken on synchronised levels; the crossover edge also follows control writes
  always_comb begin
    ev_set = '0;
    ev_set[pqs_pkg::EV_RXERR] = rx_error_evt;
    ev_set[pqs_pkg::EV_FC] = false_carrier_evt;
    ev_set[pqs_pkg::EV_POL] = lvl_s[pqs_pkg::LV_POL] & ~st.lvl_q[pqs_pkg::LV_POL];
    ev_set[pqs_pkg::EV_SIGLOSS] = ~lvl_s[pqs_pkg::LV_SIGDET] & st.lvl_q[pqs_pkg::LV_SIGDET];
    ev_set[pqs_pkg::EV_LOCKLOSS] = ~lvl_s[pqs_pkg::LV_LOCK] & st.lvl_q[pqs_pkg::LV_LOCK];
    ev_set[pqs_pkg::EV_PAGE] = page_received_evt;
    ev_set[pqs_pkg::EV_RFAULT] = lvl_s[pqs_pkg::LV_RFAULT] & ~st.lvl_q[pqs_pkg::LV_RFAULT];
    ev_set[pqs_pkg::EV_XOVER] = xover_now ^ st.xover;
  end

  pqs_event_status u_evst (
    .core_clk(core_clk),
    .srst(srst),
    .ev_set(ev_set),
    .rd_clr(rd_irq),
    .snap(st.prdata[pqs_pkg::EV_W-1:0]),
    .mask(st.mask),
    .status(irq_status),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [pqs_pkg::DATA_W-1:0] rd_word;

  // bit 15 and the uncovered low bits of the summary read as zero
  always_comb begin
    rd_word = '0;
    known = 1'b1;
    unique case (idx)
      pqs_pkg::IDX_QUICK_STATUS: begin
        rd_word[pqs_pkg::QS_RSVD] = 1'b0;
        rd_word[pqs_pkg::QS_XOVER] = st.xover;
        rd_word[pqs_pkg::QS_RXERR] = st.rxerr_l;
        rd_word[pqs_pkg::QS_POL] = st.pol_l;
        rd_word[pqs_pkg::QS_FC] = st.fc_l;
        rd_word[pqs_pkg::QS_SIGDET] = st.sd_ll;
        rd_word[pqs_pkg::QS_LOCK] = st.lock_ll;
        rd_word[pqs_pkg::QS_PAGE] = st.page_l;
        rd_word[pqs_pkg::QS_IRQ] = irq;
        rd_word[pqs_pkg::QS_RFAULT] = st.rf_l;
      end
      pqs_pkg::IDX_IRQ_STATUS: rd_word[pqs_pkg::EV_W-1:0] = irq_status;
      pqs_pkg::IDX_IRQ_MASK: rd_word[pqs_pkg::EV_W-1:0] = st.mask;
      pqs_pkg::IDX_PHY_CONTROL: begin
        rd_word[pqs_pkg::CTL_AUTO] = st.ctl_auto;
        rd_word[pqs_pkg::CTL_FORCE] = st.ctl_force;
      end
      pqs_pkg::IDX_RXERR_COUNTER: rd_word[pqs_pkg::CNT_W-1:0] = st.rxerr_cnt;
      pqs_pkg::IDX_FC_COUNTER: rd_word[pqs_pkg::CNT_W-1:0] = st.fc_cnt;
      pqs_pkg::IDX_NEG_EXPANSION: rd_word[pqs_pkg::NE_PAGE] = st.page_l;
      pqs_pkg::IDX_TEN_STATUS: rd_word[pqs_pkg::TS_POL] = st.pol_l;
      pqs_pkg::IDX_BASIC_STATUS: rd_word[pqs_pkg::BS_RFAULT] = st.rf_l;
      default: known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read data is caught in setup, so clears use exactly what was returned
  always_comb begin
    next_st = st;
    if (setup) begin
      next_st.prdata = rd_word;
      next_st.err = !known || (paddr[pqs_pkg::IDX_LSB-1:0] != pqs_pkg::ALIGN_OK);
    end
    // only mask and control take writes; summary writes fall away
    if (hit_of(wr_acc, idx, pqs_pkg::IDX_IRQ_MASK)) begin
      next_st.mask = pwdata[pqs_pkg::EV_W-1:0];
    end
    if (hit_of(wr_acc, idx, pqs_pkg::IDX_PHY_CONTROL)) begin
      next_st.ctl_auto = pwdata[pqs_pkg::CTL_AUTO];
      next_st.ctl_force = pwdata[pqs_pkg::CTL_FORCE];
    end
    next_st.xover = xover_now;
    next_st.lvl_q = lvl_s;
    // latched-high flags, each cleared by its own source register
    next_st.rxerr_l = latch_hi(st.rxerr_l, rx_error_evt, rd_rxc);
    next_st.fc_l = latch_hi(st.fc_l, false_carrier_evt, rd_fcc);
    next_st.pol_l = latch_hi(st.pol_l, lvl_s[pqs_pkg::LV_POL], rd_ten && st.prdata[pqs_pkg::TS_POL]);
    next_st.page_l = latch_hi(st.page_l, page_received_evt, rd_neg && st.prdata[pqs_pkg::NE_PAGE]);
    next_st.rf_l = latch_hi(st.rf_l, lvl_s[pqs_pkg::LV_RFAULT], rd_bas && st.prdata[pqs_pkg::BS_RFAULT]);
    // latched-low: a summary read reloads the live level
    next_st.sd_ll = rd_qs ? lvl_s[pqs_pkg::LV_SIGDET] : (st.sd_ll & lvl_s[pqs_pkg::LV_SIGDET]);
    next_st.lock_ll = rd_qs ? lvl_s[pqs_pkg::LV_LOCK] : (st.lock_ll & lvl_s[pqs_pkg::LV_LOCK]);
    // counters lose only the count the reader saw
    next_st.rxerr_cnt = cnt_step(st.rxerr_cnt, rd_rxc ? st.prdata[pqs_pkg::CNT_W-1:0] : '0, rx_error_evt);
    next_st.fc_cnt = cnt_step(st.fc_cnt, rd_fcc ? st.prdata[pqs_pkg::CNT_W-1:0] : '0, false_carrier_evt);
  end

  // state register, every summary bit starts at zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.ctl_auto <= pqs_pkg::CTL_AUTO_RST;
      st.ctl_force <= pqs_pkg::CTL_FORCE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rsvd_zero;
    @(posedge core_clk) disable iff (srst)
      rd_qs |-> !prdata[pqs_pkg::QS_RSVD] && !pslverr;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("summary bit 15 read as one");

  property p_xover_normal;
    @(posedge core_clk) disable iff (srst)
      (!st.ctl_auto && !st.ctl_force) [*2] |-> !st.xover;
  endproperty
  a_xover_normal: assert property (p_xover_normal) else $error("crossover set with auto and force off");

  property p_xover_track;
    @(posedge core_clk) disable iff (srst)
      (st.ctl_auto && !st.ctl_force) ##1 (st.ctl_auto && !st.ctl_force) |-> st.xover == $past(lvl_s[pqs_pkg::LV_SWAP]);
  endproperty
  a_xover_track: assert property (p_xover_track) else $error("crossover not tracking swap");

  property p_rxerr_hold;
    @(posedge core_clk) disable iff (srst)
      rx_error_evt ##1 !rd_rxc [*3] |-> st.rxerr_l;
  endproperty
  a_rxerr_hold: assert property (p_rxerr_hold) else $error("receive error latch lost");

  property p_pol_copy;
    @(posedge core_clk) disable iff (srst)
      lvl_s[pqs_pkg::LV_POL] |=> st.pol_l;
  endproperty
  a_pol_copy: assert property (p_pol_copy) else $error("polarity bit not set");

  property p_fc_clear;
    @(posedge core_clk) disable iff (srst)
      (rd_fcc && !false_carrier_evt) |=> !st.fc_l;
  endproperty
  a_fc_clear: assert property (p_fc_clear) else $error("false carrier latch survived counter read");

  property p_sd_low;
    @(posedge core_clk) disable iff (srst)
      (!lvl_s[pqs_pkg::LV_SIGDET] ##1 !rd_qs) |-> !st.sd_ll;
  endproperty
  a_sd_low: assert property (p_sd_low) else $error("signal detect low not held");

  property p_lock_low;
    @(posedge core_clk) disable iff (srst)
      (!lvl_s[pqs_pkg::LV_LOCK] && !rd_qs) |=> !st.lock_ll;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock loss not latched");

  property p_page_set;
    @(posedge core_clk) disable iff (srst)
      page_received_evt |=> st.page_l ##1 (st.page_l || $past(rd_neg));
  endproperty
  a_page_set: assert property (p_page_set) else $error("page received not held");

  property p_rf_set;
    @(posedge core_clk) disable iff (srst)
      lvl_s[pqs_pkg::LV_RFAULT] |=> st.rf_l;
  endproperty
  a_rf_set: assert property (p_rf_set) else $error("remote fault not set");

  property p_qs_read_keeps;
    @(posedge core_clk) disable iff (srst)
      rd_qs |=> (st.rxerr_l || !$past(st.rxerr_l)) && (st.fc_l || !$past(st.fc_l)) && (st.pol_l || !$past(st.pol_l))
        && (st.page_l || !$past(st.page_l)) && (st.rf_l || !$past(st.rf_l));
  endproperty
  a_qs_read_keeps: assert property (p_qs_read_keeps) else $error("summary read cleared a flag");

endmodule : pqs_quick_status

//--- dv/pqs_host.sv
// apb host model for the quick status bank, one transfer at a time.
// assumes core_clk is shared with the bank and xfer is entered at an edge.
`timescale 1ns/1ps
module pqs_host (
  // clock
  input wire logic core_clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [pqs_pkg::ADDR_W-1:0] paddr,
  output logic [pqs_pkg::DATA_W-1:0] pwdata,
  input wire logic [pqs_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // setup, then access held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;  // stale data must not look valid
    // one idle edge, so a following call never reassigns in this step
    @(posedge core_clk);
  endtask : xfer
endmodule : pqs_host

//--- dv/tb.sv
// self-checking bench for the phy quick status bank.
// assumes the host model drives all apb traffic; events and levels from here.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // signals, instances, clock
  // ----------------------------------------------------------------
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [pqs_pkg::ADDR_W-1:0] paddr;
  logic [pqs_pkg::DATA_W-1:0] pwdata, prdata;
  logic rx_error_evt, false_carrier_evt, page_received_evt, pair_swap;
  logic signal_detect, descrambler_lock, polarity_inverted, remote_fault_ind;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [7:0] A_QS = 8'h40;
  localparam logic [31:0] B = 32'h0000_0600;  // detect and lock live
  pqs_quick_status i_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_error_evt, .false_carrier_evt, .page_received_evt, .signal_detect,
    .descrambler_lock, .polarity_inverted, .remote_fault_ind, .pair_swap, .irq);
  pqs_host i_host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // 50 mhz core clock
  always #10 core_clk = ~core_clk;
  // hang guard, run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      $display("[FAIL] run length expected finish seen hang");
      stop_test();
    end
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic chk_bit(input string s, input logic x, input logic g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", s, x, g);
    end
  endtask : chk_bit
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    i_host.xfer(1'b0, a, '0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b1, a, d, q, e);
    chk_bit("write err", 1'b0, e);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    rd(a, q);
    chk(s, x, q);
  endtask : rdc
  // one-cycle event pulse: 0 rx error, 1 false carrier, 2 page
  task automatic pulse(input int k);
    rx_error_evt <= (k == 0);
    false_carrier_evt <= (k == 1);
    page_received_evt <= (k == 2);
    @(posedge core_clk);
    {rx_error_evt, false_carrier_evt, page_received_evt} <= 3'b000;
    @(posedge core_clk);
  endtask : pulse
  // levels need four edges through the synchroniser
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask : settle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle();
    rdc("qs reset", A_QS, '0);
    rdc("qs reload", A_QS, B);
    wr(A_QS, 32'hFFFF_FFFF);
    rdc("qs top bit", A_QS, B);
    rdc("ctl reset", 8'h64, 32'h0000_0002);
    rdc("mask reset", 8'h4C, '0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_low();
    signal_detect <= 1'b0;
    settle();
    signal_detect <= 1'b1;
    descrambler_lock <= 1'b0;
    settle();
    descrambler_lock <= 1'b1;
    settle();
    rdc("qs lows", A_QS, '0);
    rdc("qs relive", A_QS, B);
    $display("t_low done");
  endtask : t_low
  task automatic t_cnt();
    logic [31:0] m;
    for (int k = 0; k < 2; k++) begin
      m = k ? 32'h0000_0800 : 32'h0000_2000;
      pulse(k);
      pulse(k);
      rdc("qs latch", A_QS, B | m);
      rdc("qs kept", A_QS, B | m);
      rdc("counter", k ? 8'h50 : 8'h54, 32'h0000_0002);
      rdc("qs cleared", A_QS, B);
    end
    $display("t_cnt done");
  endtask : t_cnt
  task automatic t_copy();
    logic [31:0] q;
    polarity_inverted <= 1'b1;
    remote_fault_ind <= 1'b1;
    settle();
    polarity_inverted <= 1'b0;
    remote_fault_ind <= 1'b0;
    settle();
    rdc("qs copies", A_QS, B | 32'h0000_1040);
    rdc("ten status", 8'h68, 32'h0000_0010);
    rdc("qs pol gone", A_QS, B | 32'h0000_0040);
    rd(8'h04, q);
    chk_bit("basic rf", 1'b1, q[4]);
    rdc("qs rf gone", A_QS, B);
    pulse(2);
    rdc("qs page", A_QS, B | 32'h0000_0100);
    rd(8'h18, q);
    chk_bit("exp page", 1'b1, q[1]);
    rdc("qs page gone", A_QS, B);
    $display("t_copy done");
  endtask : t_copy
  task automatic t_irq();
    logic [31:0] q;
    rdc("status all", 8'h48, 32'h0000_007F);
    wr(8'h4C, 32'h0000_0001);
    rdc("mask", 8'h4C, 32'h0000_0001);
    pulse(1);
    chk_bit("irq masked", 1'b0, irq);
    pulse(0);
    chk_bit("irq up", 1'b1, irq);
    rdc("qs irq", A_QS, B | 32'h0000_2880);
    rdc("status", 8'h48, 32'h0000_0003);
    chk_bit("irq down", 1'b0, irq);
    rdc("qs irq gone", A_QS, B | 32'h0000_2800);
    rd(8'h50, q);
    rd(8'h54, q);
    wr(8'h4C, '0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_xover();
    pair_swap <= 1'b1;
    settle();
    rdc("xover swap", A_QS, B | 32'h0000_4000);
    pair_swap <= 1'b0;
    settle();
    rdc("xover normal", A_QS, B);
    wr(8'h64, 32'h0000_0001);
    rdc("xover forced", A_QS, B | 32'h0000_4000);
    pair_swap <= 1'b1;
    wr(8'h64, '0);
    settle();
    rdc("xover off", A_QS, B);
    wr(8'h64, 32'h0000_0002);
    rdc("xover auto", A_QS, B | 32'h0000_4000);
    pair_swap <= 1'b0;
    $display("t_xover done");
  endtask : t_xover
  task automatic t_err();
    logic [31:0] q;
    logic e;
    i_host.xfer(1'b0, 8'h08, '0, q, e);
    chk("unmapped data", '0, q);
    chk_bit("unmapped err", 1'b1, e);
    i_host.xfer(1'b0, 8'h41, '0, q, e);
    chk_bit("misaligned err", 1'b1, e);
    pulse(0);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdc("qs mid reset", A_QS, '0);
    rdc("rxc mid reset", 8'h54, '0);
    rdc("status mid reset", 8'h48, '0);
    $display("t_err done");
  endtask : t_err
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    {core_clk, rx_error_evt, false_carrier_evt, page_received_evt} = '0;
    {polarity_inverted, remote_fault_ind, pair_swap} = '0;
    {signal_detect, descrambler_lock, srst} = 3'b111;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_low();
    t_cnt();
    t_copy();
    t_irq();
    t_xover();
    t_err();
    stop_test();
  end
endmodule : tb
